// *** core/hcr_pkg.sv ***
// Purpose: Shared constants and carriers for the host controller config registers
// Assumes: 32-bit APB, byte addresses of own choosing
// Notes:   Single clock pclk at 40 MHz
package hcr_pkg;
  localparam logic [11:0] ADDR_ROM_BASE   = 12'h000;
  localparam logic [11:0] ADDR_VENDOR_ID  = 12'h004;
  localparam logic [11:0] ADDR_CTRL_SET   = 12'h008;
  localparam logic [11:0] ADDR_CTRL_CLEAR = 12'h00c;

  localparam int          ROM_BASE_LSB    = 10;
  localparam logic [31:0] ROM_BASE_MASK   = 32'hffff_fc00;
  localparam logic [31:0] ROM_BASE_RESET  = 32'h0000_0000;

  localparam int          VID_ORG_LSB     = 0;
  localparam int          VID_VEND_LSB    = 24;
  localparam logic [23:0] VID_ORG_NONE    = 24'h00_0000;

  localparam int          CTRL_PHY_PERMIT = 23;
  localparam int          CTRL_LINK_EN    = 17;
  localparam int          CTRL_BIG_ENDIAN = 30;
  localparam logic [31:0] CTRL_SET_MASK   = 32'h4002_0000;
  localparam logic [31:0] CTRL_CLR_MASK   = 32'h4080_0000;

  localparam logic [47:0] ROM_WIN_FIRST   = 48'hffff_f000_0400;
  localparam logic [47:0] ROM_WIN_LAST    = 48'hffff_f000_07ff;
  localparam logic [9:0]  ROM_LOCAL_END   = 10'h014;

  typedef struct packed {
    logic        valid;
    logic        quadlet_read;
    logic [47:0] offset;
  } hcr_req_t;

  typedef struct packed {
    logic        valid;
    logic        type_error;
    logic        local_hit;
    logic [2:0]  local_index;
    logic [31:0] host_addr;
  } hcr_resp_t;
endpackage : hcr_pkg

// *** core/hcr_swap.sv ***
// Purpose: Registered quadlet byte-order stage
// Assumes: Select held stable while link active
// Notes:   Little endian reverses byte lanes
module hcr_swap (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        big_endian,
  input  wire logic [31:0] din,
  output logic      [31:0] dout
);
  wire logic [31:0] swapped = {din[7:0], din[15:8], din[23:16], din[31:24]};
  wire logic [31:0] next_dout = big_endian ? din : swapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 32'h0000_0000;
    end else begin
      dout <= next_dout;
    end
  end
endmodule : hcr_swap

// *** core/hcr_top.sv ***
// Purpose: Config ROM map base, vendor id and set/clear control flags over APB
// Assumes: Requests from link logic on pclk; soft_reset is a pclk-domain pulse
// Notes:   Answers ROM map requests one cycle after the request
// Behaviour
// (R1) Only ROM-window quadlet reads map, others error
// (R2) Low ten base bits forced zero
// (R3) Host address is base plus offset
// (R4) First five quadlets answered locally
// (R5) Software loads base before link enable
// (R6) Vendor id read-only, fields 31:24, 23:0
// (R7) Organization id reads zero without extras
// (R8) Flags readable at set and clear aliases
// (R9) Set alias ones set bits
// (R10) Clear alias ones clear bits
// (R11) Big endian select steers data byte order
// (R12) Software changes endian only link off
// (R13) Endian select implemented here
// (R14) PHY permit is clear-only
// (R15) Software enables enhancements only when permitted
// (R16) PHY permit loads at hard reset only
// (R17) Link enable resets zero, set-only
// (R18) Unimplemented control bits read zero
module hcr_top #(
  parameter logic [7:0] VENDOR_BITS = 8'h00,
  parameter logic       PHY_CAPABLE = 1'b1
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  input  wire logic                soft_reset,
  input  wire hcr_pkg::hcr_req_t   rom_req,
  output hcr_pkg::hcr_resp_t       rom_resp,
  input  wire logic [31:0]         dma_data_in,
  output logic      [31:0]         dma_data_out,
  output logic                     link_active_en,
  output logic                     data_big_endian_sel,
  output logic                     phy_enhance_permit
);
  logic [31:0] rom_window_base;
  logic [31:0] host_ctrl_flags;

  // Bus decode
  wire logic        access   = psel && penable;
  wire logic        wr       = access && pwrite;
  wire logic        hit_base = (paddr == hcr_pkg::ADDR_ROM_BASE);
  wire logic        hit_vid  = (paddr == hcr_pkg::ADDR_VENDOR_ID);
  wire logic        hit_set  = (paddr == hcr_pkg::ADDR_CTRL_SET);
  wire logic        hit_clr  = (paddr == hcr_pkg::ADDR_CTRL_CLEAR);
  wire logic        hit_any  = hit_base || hit_vid || hit_set || hit_clr;

  // (R6) Read-only id fields
  wire logic [31:0] vendor_identification = {VENDOR_BITS, hcr_pkg::VID_ORG_NONE}; // (R7) none extra

  // (R9) Set alias mask
  wire logic [31:0] set_bits = (wr && hit_set) ? (pwdata & hcr_pkg::CTRL_SET_MASK) : 32'h0000_0000;
  // (R10) Clear alias mask
  wire logic [31:0] clr_bits = (wr && hit_clr) ? (pwdata & hcr_pkg::CTRL_CLR_MASK) : 32'h0000_0000;
  // (R18) Reserved stay zero
  wire logic [31:0] impl_mask = hcr_pkg::CTRL_SET_MASK | hcr_pkg::CTRL_CLR_MASK;
  wire logic [31:0] next_flags = ((host_ctrl_flags & ~clr_bits) | set_bits) & impl_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pslverr <= psel && !penable && !hit_any;
    end
  end

  // (R2) Base low bits zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_window_base <= hcr_pkg::ROM_BASE_RESET;
    end else if (wr && pready && hit_base) begin
      rom_window_base <= pwdata & hcr_pkg::ROM_BASE_MASK;
    end
  end

  // (R16) Permit loads at hard reset only; (R17) link enable cleared by soft reset
  wire logic [31:0] soft_clear = soft_reset ? (32'h1 << hcr_pkg::CTRL_LINK_EN) : 32'h0000_0000;
  wire logic [31:0] hw_reset_flags = {8'h00, PHY_CAPABLE, 23'h00_0000};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ctrl_flags <= 32'h0000_0000;
    end else if (!pready) begin
      host_ctrl_flags <= host_ctrl_flags & ~soft_clear;
    end else begin
      host_ctrl_flags <= next_flags & ~soft_clear;
    end
  end

  // Permit strap captured right after reset release
  logic started;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  logic permit;
  // (R14) Permit clear-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit <= 1'b0;
    end else if (!started) begin
      permit <= hw_reset_flags[hcr_pkg::CTRL_PHY_PERMIT];
    end else if (pready && clr_bits[hcr_pkg::CTRL_PHY_PERMIT]) begin
      permit <= 1'b0;
    end
  end

  wire logic [31:0] flags_view = {host_ctrl_flags[31:24], permit, host_ctrl_flags[22:0]};

  // (R8) Both aliases read flags, permit included
  wire logic [31:0] rd_mux =
    hit_base ? rom_window_base :
    hit_vid  ? vendor_identification :
    (hit_set || hit_clr) ? flags_view : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_active_en      <= 1'b0;
      data_big_endian_sel <= 1'b0;
      phy_enhance_permit  <= 1'b0;
    end else begin
      link_active_en      <= flags_view[hcr_pkg::CTRL_LINK_EN];
      data_big_endian_sel <= flags_view[hcr_pkg::CTRL_BIG_ENDIAN];
      phy_enhance_permit  <= permit;
    end
  end

  // ROM window decode
  wire logic        in_win   = (rom_req.offset >= hcr_pkg::ROM_WIN_FIRST) &&
                               (rom_req.offset <= hcr_pkg::ROM_WIN_LAST);
  wire logic        good_req = in_win && rom_req.quadlet_read && (rom_req.offset[1:0] == 2'b00);
  wire logic [9:0]  rom_off  = rom_req.offset[9:0];
  wire logic        is_local = rom_off < hcr_pkg::ROM_LOCAL_END;
  wire logic [31:0] sum_addr = rom_window_base + {22'h00_0000, rom_off};

  hcr_pkg::hcr_resp_t next_resp;
  always_comb begin
    next_resp             = '0;
    next_resp.valid       = rom_req.valid;
    // (R1) Reject non-quadlet-read
    next_resp.type_error  = rom_req.valid && !good_req;
    // (R4) Header served locally
    next_resp.local_hit   = rom_req.valid && good_req && is_local;
    next_resp.local_index = rom_off[4:2];
    // (R3) Base plus offset
    next_resp.host_addr   = (rom_req.valid && good_req && !is_local) ? sum_addr : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_resp <= '0;
    end else begin
      rom_resp <= next_resp;
    end
  end

  // (R11) Endian steering; (R13) always present
  hcr_swap u_swap (
    .pclk       (pclk),
    .presetn    (presetn),
    .big_endian (data_big_endian_sel),
    .din        (dma_data_in),
    .dout       (dma_data_out)
  );

  AST_LOW_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    rom_window_base[9:0] == 10'h000) else $error("base low bits nonzero"); // (R2)
  AST_VID_RO: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_vid) |=> prdata == {VENDOR_BITS, 24'h00_0000})
    else $error("vendor id wrong"); // (R6)
  AST_ORG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    vendor_identification[23:0] == 24'h00_0000) else $error("org id nonzero"); // (R7)
  AST_ALIAS_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && (hit_set || hit_clr)) |=> prdata == $past(flags_view))
    else $error("alias read mismatch"); // (R8)
  AST_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && pready && hit_set && pwdata[17] && !soft_reset) |=> ##1 link_active_en)
    else $error("set failed"); // (R9)
  AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && pready && hit_clr && pwdata[30]) |=> ##1 !data_big_endian_sel) else $error("clear failed"); // (R10)
  AST_LINK_NOCLR: assert property (@(posedge pclk) disable iff (!presetn)
    (host_ctrl_flags[17] && !soft_reset) |=> host_ctrl_flags[17]) else $error("link cleared"); // (R17)
  AST_PERMIT: assert property (@(posedge pclk) disable iff (!presetn)
    (started && !permit) |=> !permit) else $error("permit rose"); // (R14)
  AST_RESV: assert property (@(posedge pclk) disable iff (!presetn)
    (host_ctrl_flags & ~impl_mask) == 32'h0000_0000) else $error("reserved set"); // (R18)
  AST_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
    (rom_req.valid && !rom_req.quadlet_read) |=> rom_resp.type_error) else $error("no reject"); // (R1)
  AST_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    (rom_req.valid && good_req && !is_local) |=> rom_resp.host_addr == $past(sum_addr))
    else $error("bad host addr"); // (R3)
  AST_LOCAL: assert property (@(posedge pclk) disable iff (!presetn)
    (rom_resp.local_hit) |-> rom_resp.host_addr == 32'h0000_0000) else $error("local fetched"); // (R4)
  AST_PERMIT_SOFT: assert property (@(posedge pclk) disable iff (!presetn)
    (started && soft_reset && !clr_bits[23]) |=> permit == $past(permit)) else $error("soft hit permit"); // (R16)

  COV_WRITE_BASE: cover property (@(posedge pclk) disable iff (!presetn) wr && pready && hit_base);
  COV_LINK_UP:    cover property (@(posedge pclk) disable iff (!presetn) $rose(link_active_en));
  COV_MAPPED:     cover property (@(posedge pclk) disable iff (!presetn) rom_resp.valid && !rom_resp.local_hit);
  COV_ERROR:      cover property (@(posedge pclk) disable iff (!presetn) rom_resp.type_error);
endmodule : hcr_top

// *** tb/hcr_link_model.sv ***
// Purpose: Link-side requester issuing config ROM reads
// Assumes: One request per go pulse from the bench
// Notes:   Idle fields invert each cycle so stale values never pass
module hcr_link_model (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         go,
  input  wire logic         quad,
  input  wire logic [47:0]  off,
  output hcr_pkg::hcr_req_t rom_req
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_req <= '0;
    end else begin
      rom_req.valid        <= go;
      rom_req.quadlet_read <= go ? quad : ~rom_req.quadlet_read;
      rom_req.offset       <= go ? off : ~rom_req.offset;
    end
  end
endmodule : hcr_link_model

// *** tb/tb_host_ctrl_config_regs.sv ***
// Purpose: Self-checking bench for the config register block
// Assumes: APB answers without wait states, PHY_CAPABLE left at 1
// Notes:   Expected reads queue up, a monitor pops them
module tb_host_ctrl_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic soft_reset = 0, go = 0, quad = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, dma_data_in = '0, prdata, dma_data_out, base, rnd = 32'h82b0;
  logic [47:0] off = '0;
  logic pready, pslverr, link_active_en, data_big_endian_sel, phy_enhance_permit;
  hcr_pkg::hcr_req_t  rom_req;
  hcr_pkg::hcr_resp_t rom_resp;
  hcr_pkg::hcr_resp_t q_rom[$];
  logic [32:0]        q_bus[$];
  int n_mismatch = 0, tests_run = 0;

  always #12.5 pclk = ~pclk;

  hcr_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
                 .soft_reset, .rom_req, .rom_resp, .dma_data_in, .dma_data_out, .link_active_en,
                 .data_big_endian_sel, .phy_enhance_permit);
  hcr_link_model u_link (.pclk, .presetn, .go, .quad, .off, .rom_req);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic note(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : note

  task automatic chk_bus(input logic [32:0] g, input logic [32:0] e);
    note(g === e, "bus read");
  endtask : chk_bus

  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
    note(g === e, "output pins");
  endtask : chk_pin

  task automatic chk_rom(input hcr_pkg::hcr_resp_t g, input hcr_pkg::hcr_resp_t e);
    logic ok;
    ok = g.type_error === e.type_error;
    if (!e.type_error)
      ok = ok && g.local_hit === e.local_hit && (e.local_hit ? g.local_index === e.local_index
                                                            : g.host_addr === e.host_addr);
    note(ok, "rom answer");
  endtask : chk_rom

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) q_bus.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rom(input logic q, input logic [47:0] o, input logic te, input logic lh);
    q_rom.push_back('{1'b1, te, lh, o[4:2], base + {22'h0, o[9:0]}});
    @(posedge pclk);
    go   <= 1'b1;
    quad <= q;
    off  <= o;
    @(posedge pclk);
    go   <= 1'b0;
  endtask : rom

  task automatic dma(input logic [31:0] v, input logic [31:0] e);
    @(posedge pclk);
    dma_data_in <= v;
    repeat (2) @(posedge pclk);
    #1 chk_pin(dma_data_out, e);
  endtask : dma

  // Pops the oldest expected value whenever a read completes or a ROM answer shows
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (q_bus.size() == 0) note(1'b0, "unexpected read");
      else chk_bus({pslverr, prdata}, q_bus.pop_front());
    end
    if (rom_resp.valid === 1'b1) begin
      if (q_rom.size() == 0) note(1'b0, "unexpected rom answer");
      else chk_rom(rom_resp, q_rom.pop_front());
    end
  end

  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, hcr_pkg::ADDR_CTRL_SET, 0, 33'h0_0080_0000);
    apb(0, hcr_pkg::ADDR_VENDOR_ID, 0, 33'h0);
    apb(1, hcr_pkg::ADDR_VENDOR_ID, 32'hffff_ffff, 0);
    apb(0, hcr_pkg::ADDR_VENDOR_ID, 0, 33'h0);
    rnd  = lfsr(rnd);
    base = rnd & 32'hffff_fc00;
    apb(1, hcr_pkg::ADDR_ROM_BASE, rnd, 0);
    apb(0, hcr_pkg::ADDR_ROM_BASE, 0, {1'b0, base});
    apb(0, 12'h010, 0, 33'h1_0000_0000);
    apb(1, hcr_pkg::ADDR_CTRL_SET, 32'hffff_ffff, 0);
    apb(0, hcr_pkg::ADDR_CTRL_CLEAR, 0, 33'h0_4082_0000);
    #1 chk_pin({29'h0, link_active_en, data_big_endian_sel, phy_enhance_permit}, 32'h7);
    rom(1, 48'hffff_f000_0400, 0, 1);
    rom(1, 48'hffff_f000_0410, 0, 1);
    rom(1, 48'hffff_f000_0414, 0, 0);
    rom(1, 48'hffff_f000_07fc, 0, 0);
    rom(1, 48'hffff_f000_0800, 1, 0);
    rom(0, 48'hffff_f000_0500, 1, 0);
    rnd = lfsr(rnd);
    dma(rnd, rnd);
    apb(1, hcr_pkg::ADDR_CTRL_CLEAR, 32'h0082_0000, 0);
    apb(0, hcr_pkg::ADDR_CTRL_SET, 0, 33'h0_4002_0000);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    apb(0, hcr_pkg::ADDR_CTRL_SET, 0, 33'h0_4000_0000);
    apb(1, hcr_pkg::ADDR_CTRL_CLEAR, 32'hffff_ffff, 0);
    apb(0, hcr_pkg::ADDR_CTRL_CLEAR, 0, 33'h0);
    dma(32'h1122_3344, 32'h4433_2211);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, hcr_pkg::ADDR_CTRL_SET, 0, 33'h0_0080_0000);
    repeat (3) @(posedge pclk);
    report_and_stop;
  end
endmodule : tb_host_ctrl_config_regs
